// ==== include/power_list_map.svh ====
// Register map, field positions, reset values and timing of the sequencer
`ifndef POWER_LIST_MAP_SVH
`define POWER_LIST_MAP_SVH

// ==========================================================
// Register byte offsets
`define OFS_CTRL 12'h000
`define OFS_CMD 12'h004
`define OFS_LIST_LEN 12'h008
`define OFS_REPEAT 12'h00c
`define OFS_VOLT_LEVEL 12'h010
`define OFS_CURR_LEVEL 12'h014
`define OFS_POST_TRIG 12'h018
`define OFS_PROT_DELAY 12'h01c
`define OFS_OPER_COND 12'h020
`define OFS_QUES_COND 12'h024
`define OFS_QUES_EVENT 12'h028
`define OFS_QUES_MASK 12'h02c
`define OFS_QUES_PTR 12'h030
`define OFS_SRQ_MASK 12'h034
`define OFS_STATUS_BYTE 12'h038
`define OFS_VOLT_TAB 12'h100
`define OFS_CURR_TAB 12'h180
`define OFS_DWELL_TAB 12'h200

// ==========================================================
// Field positions
`define CTRL_VOLT_LIST 0
`define CTRL_CURR_LIST 1
`define CTRL_OUT_ON 2
`define CTRL_OCP_EN 3
`define CTRL_EXT_TRIG 4
`define CTRL_STEP_TRIG 5
`define CTRL_W 6
`define CMD_ARM 0
`define CMD_FIRE 1
`define CMD_ABORT 2
`define REPEAT_ENDLESS 16
`define OPER_RUN 0
`define OPER_WAIT 5
`define QUES_OC 1
`define SRE_QUES 3
`define STB_QUES 3
`define STB_RQS 6

// ==========================================================
// Sizes and reset values
`define LIST_DEPTH 20
`define CTRL_RST 6'h00
`define LIST_LEN_RST 5'h01
`define REPEAT_RST 16'h0001
`define LEVEL_RST 16'h0000

// ==========================================================
// Timing
`define CLK_NS 20
`define DWELL_TICK_MS 10
`define DWELL_TICK_NS 10000000
`define DWELL_MAX_MS 65000
`define DWELL_MIN_TICKS (`DWELL_TICK_MS / `DWELL_TICK_MS)
`define DWELL_MAX_TICKS (`DWELL_MAX_MS / `DWELL_TICK_MS)

`endif

// ==== include/power_list_pkg.sv ====
// Types shared by the list sequencer
package power_list_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_RUN} seq_state_e;
    typedef logic [15:0] level_t;
    typedef logic [4:0] idx_t;
    typedef logic [11:0] addr_t;
endpackage

// ==== src/power_list_sequencer.sv ====
// List sequencer with trigger, status and overcurrent protection, APB slave
//
// Operation
// - Voltage list mode drives the voltage set point from table entries.
// - Current list mode drives the current limit from entries in order.
// - Each entry is held for its dwell, then the next follows unaided.
// - After the last dwell with no repeat, the last value stays.
// - Endless repeat restarts the list after every pass until stopped.
// - The table holds up to twenty entries.
// - Arming readies the trigger; the list waits for a later trigger.
// - Waiting for trigger shows in operation bit 5; host polls it.
// - The host fire-now command is always accepted as a trigger.
// - One trigger starts the list and loads the post-trigger voltage.
// - Overcurrent shows in questionable bit 1, gated by a mask.
// - With the rising filter set, only a rise latches the event.
// - Service request enable bit 3 lets masked events raise a request.
// - Protection on plus current regulation turns output off, halts list.
// - A protection delay of zero trips at once.
// - An external trigger input may start the list instead.
// - A trigger pulse may go out at every entry change.
// - Several modules can start together from one shared trigger.
// - Dwell ranges from ten milliseconds to sixty-five seconds.
//
// The implementer's own choices: the APB slave port and the placing of the registers.
`include "power_list_map.svh"

module power_list_sequencer #(
    parameter int unsigned TICK_CYCLES = `DWELL_TICK_NS / `CLK_NS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire power_list_pkg::addr_t paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic constant_current_regulation,
    input wire logic ext_trig_in,
    output logic trig_out,
    output logic output_on,
    output power_list_pkg::level_t volt_setpoint,
    output power_list_pkg::level_t curr_limit,
    output logic srq
);
    import power_list_pkg::*;

    // ==========================================================
    // Decoding helpers
    function automatic logic in_tab(input addr_t a, input addr_t base);
        in_tab = (a >= base) && (a < base + addr_t'(4 * `LIST_DEPTH))
            && (a[1:0] == 2'h0);
    endfunction

    function automatic idx_t tab_idx(input addr_t a, input addr_t base);
        addr_t off;
        off = a - base;
        tab_idx = off[6:2];
    endfunction

    function automatic logic mapped(input addr_t a);
        mapped = (a <= `OFS_STATUS_BYTE && a[1:0] == 2'h0)
            || in_tab(a, `OFS_VOLT_TAB) || in_tab(a, `OFS_CURR_TAB)
            || in_tab(a, `OFS_DWELL_TAB);
    endfunction

    // Out-of-range dwell values are pulled into the legal span
    function automatic level_t clamp_dwell(input level_t d);
        if (d < level_t'(`DWELL_MIN_TICKS)) begin
            clamp_dwell = level_t'(`DWELL_MIN_TICKS);
        end else if (d > level_t'(`DWELL_MAX_TICKS)) begin
            clamp_dwell = level_t'(`DWELL_MAX_TICKS);
        end else begin
            clamp_dwell = d;
        end
    endfunction

    // ==========================================================
    // State
    logic [`CTRL_W-1:0] ctrl_q, ctrl_d;
    idx_t list_len_q, list_len_d;
    level_t rep_count_q, rep_count_d;
    logic endless_q, endless_d;
    level_t volt_level_q, volt_level_d;
    level_t curr_level_q, curr_level_d;
    level_t post_trig_q, post_trig_d;
    level_t prot_delay_q, prot_delay_d;
    level_t ques_event_q, ques_event_d;
    level_t ques_mask_q, ques_mask_d;
    level_t ques_ptr_q, ques_ptr_d;
    logic [7:0] sre_q, sre_d;
    level_t vtab_q [`LIST_DEPTH];
    level_t vtab_d [`LIST_DEPTH];
    level_t ctab_q [`LIST_DEPTH];
    level_t ctab_d [`LIST_DEPTH];
    level_t dtab_q [`LIST_DEPTH];
    level_t dtab_d [`LIST_DEPTH];
    logic [31:0] prdata_q, prdata_d;

    seq_state_e state_q, state_d;
    idx_t idx_q, idx_d;
    level_t dwell_left_q, dwell_left_d;
    logic [31:0] tick_q, tick_d;
    level_t rep_left_q, rep_left_d;
    logic step_q, step_d;
    logic ext_prev_q, ext_prev_d;
    level_t volt_sp_q, volt_sp_d;
    level_t curr_sp_q, curr_sp_d;

    level_t oc_cnt_q, oc_cnt_d;
    logic cc_prev_q, cc_prev_d;

    // ==========================================================
    // Common terms
    logic setup, wr, cmd_wr, arm_cmd, fire_cmd, abort_cmd, fire;
    logic oc_trip, tick_done, oc_rise, summary;
    idx_t last_idx;
    logic [31:0] rdata;
    level_t oper_cond, ques_cond, status_byte;

    assign setup = psel && !penable;
    assign wr = psel && penable && pwrite && mapped(paddr);
    assign cmd_wr = wr && (paddr == `OFS_CMD);
    assign arm_cmd = cmd_wr && pwdata[`CMD_ARM];
    assign fire_cmd = cmd_wr && pwdata[`CMD_FIRE];
    assign abort_cmd = cmd_wr && pwdata[`CMD_ABORT];
    // Host command always counts; the external pin only when selected
    assign fire = fire_cmd
        || (ctrl_q[`CTRL_EXT_TRIG] && ext_trig_in && !ext_prev_q);
    // Zero delay: the counter already equals the setting on detection
    assign oc_trip = ctrl_q[`CTRL_OCP_EN] && constant_current_regulation
        && (oc_cnt_q >= prot_delay_q);
    assign tick_done = (tick_q == TICK_CYCLES - 1);
    assign last_idx = (list_len_q == 5'h00) ? 5'h00 :
        (list_len_q > 5'(`LIST_DEPTH)) ? 5'(`LIST_DEPTH - 1) :
        list_len_q - 5'h01;
    assign oc_rise = constant_current_regulation && !cc_prev_q
        && ques_ptr_q[`QUES_OC];
    assign summary = |(ques_event_q & ques_mask_q);

    always_comb begin
        oper_cond = '0;
        oper_cond[`OPER_WAIT] = (state_q == ST_ARMED);
        oper_cond[`OPER_RUN] = (state_q == ST_RUN);
        ques_cond = '0;
        ques_cond[`QUES_OC] = constant_current_regulation;
        status_byte = '0;
        status_byte[`STB_QUES] = summary;
        status_byte[`STB_RQS] = srq;
    end

    assign srq = summary && sre_q[`SRE_QUES];
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped(paddr);
    assign prdata = prdata_q;
    assign output_on = ctrl_q[`CTRL_OUT_ON];
    assign volt_setpoint = volt_sp_q;
    assign curr_limit = curr_sp_q;
    assign trig_out = step_q;

    // ==========================================================
    // Read mux
    always_comb begin
        rdata = 32'h0000_0000;
        if (in_tab(paddr, `OFS_VOLT_TAB)) begin
            rdata[15:0] = vtab_q[tab_idx(paddr, `OFS_VOLT_TAB)];
        end else if (in_tab(paddr, `OFS_CURR_TAB)) begin
            rdata[15:0] = ctab_q[tab_idx(paddr, `OFS_CURR_TAB)];
        end else if (in_tab(paddr, `OFS_DWELL_TAB)) begin
            rdata[15:0] = dtab_q[tab_idx(paddr, `OFS_DWELL_TAB)];
        end else begin
            unique case (paddr)
                `OFS_CTRL: rdata[`CTRL_W-1:0] = ctrl_q;
                `OFS_LIST_LEN: rdata[4:0] = list_len_q;
                `OFS_REPEAT: rdata[16:0] = {endless_q, rep_count_q};
                `OFS_VOLT_LEVEL: rdata[15:0] = volt_level_q;
                `OFS_CURR_LEVEL: rdata[15:0] = curr_level_q;
                `OFS_POST_TRIG: rdata[15:0] = post_trig_q;
                `OFS_PROT_DELAY: rdata[15:0] = prot_delay_q;
                `OFS_OPER_COND: rdata[15:0] = oper_cond;
                `OFS_QUES_COND: rdata[15:0] = ques_cond;
                `OFS_QUES_EVENT: rdata[15:0] = ques_event_q;
                `OFS_QUES_MASK: rdata[15:0] = ques_mask_q;
                `OFS_QUES_PTR: rdata[15:0] = ques_ptr_q;
                `OFS_SRQ_MASK: rdata[7:0] = sre_q;
                `OFS_STATUS_BYTE: rdata[15:0] = status_byte;
                default: rdata = 32'h0000_0000;
            endcase
        end
    end

    // ==========================================================
    // Software registers
    always_comb begin
        ctrl_d = ctrl_q;
        list_len_d = list_len_q;
        rep_count_d = rep_count_q;
        endless_d = endless_q;
        volt_level_d = volt_level_q;
        curr_level_d = curr_level_q;
        post_trig_d = post_trig_q;
        prot_delay_d = prot_delay_q;
        ques_mask_d = ques_mask_q;
        ques_ptr_d = ques_ptr_q;
        sre_d = sre_q;
        vtab_d = vtab_q;
        ctab_d = ctab_q;
        dtab_d = dtab_q;
        ques_event_d = ques_event_q;
        prdata_d = setup ? rdata : prdata_q;
        if (wr) begin
            if (in_tab(paddr, `OFS_VOLT_TAB)) begin
                vtab_d[tab_idx(paddr, `OFS_VOLT_TAB)] = pwdata[15:0];
            end else if (in_tab(paddr, `OFS_CURR_TAB)) begin
                ctab_d[tab_idx(paddr, `OFS_CURR_TAB)] = pwdata[15:0];
            end else if (in_tab(paddr, `OFS_DWELL_TAB)) begin
                dtab_d[tab_idx(paddr, `OFS_DWELL_TAB)] = pwdata[15:0];
            end else begin
                unique case (paddr)
                    `OFS_CTRL: ctrl_d = pwdata[`CTRL_W-1:0];
                    `OFS_LIST_LEN: list_len_d = pwdata[4:0];
                    `OFS_REPEAT: begin
                        rep_count_d = pwdata[15:0];
                        endless_d = pwdata[`REPEAT_ENDLESS];
                    end
                    `OFS_VOLT_LEVEL: volt_level_d = pwdata[15:0];
                    `OFS_CURR_LEVEL: curr_level_d = pwdata[15:0];
                    `OFS_POST_TRIG: post_trig_d = pwdata[15:0];
                    `OFS_PROT_DELAY: prot_delay_d = pwdata[15:0];
                    // Write one to clear
                    `OFS_QUES_EVENT:
                        ques_event_d = ques_event_q & ~pwdata[15:0];
                    `OFS_QUES_MASK: ques_mask_d = pwdata[15:0];
                    `OFS_QUES_PTR: ques_ptr_d = pwdata[15:0];
                    `OFS_SRQ_MASK: sre_d = pwdata[7:0];
                    default: ctrl_d = ctrl_q;
                endcase
            end
        end
        // A new event wins over a clear in the same cycle
        if (oc_rise) begin
            ques_event_d[`QUES_OC] = 1'b1;
        end
        if (state_q == ST_ARMED && fire && !abort_cmd && !oc_trip) begin
            volt_level_d = post_trig_q;
        end
        // Safety first: a trip beats a software enable in the same cycle
        if (oc_trip) begin
            ctrl_d[`CTRL_OUT_ON] = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `CTRL_RST;
            list_len_q <= `LIST_LEN_RST;
            rep_count_q <= `REPEAT_RST;
            endless_q <= 1'b0;
            volt_level_q <= `LEVEL_RST;
            curr_level_q <= `LEVEL_RST;
            post_trig_q <= `LEVEL_RST;
            prot_delay_q <= `LEVEL_RST;
            ques_event_q <= `LEVEL_RST;
            ques_mask_q <= `LEVEL_RST;
            ques_ptr_q <= `LEVEL_RST;
            sre_q <= 8'h00;
            vtab_q <= '{default: `LEVEL_RST};
            ctab_q <= '{default: `LEVEL_RST};
            dtab_q <= '{default: `LEVEL_RST};
            prdata_q <= 32'h0000_0000;
        end else begin
            ctrl_q <= ctrl_d;
            list_len_q <= list_len_d;
            rep_count_q <= rep_count_d;
            endless_q <= endless_d;
            volt_level_q <= volt_level_d;
            curr_level_q <= curr_level_d;
            post_trig_q <= post_trig_d;
            prot_delay_q <= prot_delay_d;
            ques_event_q <= ques_event_d;
            ques_mask_q <= ques_mask_d;
            ques_ptr_q <= ques_ptr_d;
            sre_q <= sre_d;
            vtab_q <= vtab_d;
            ctab_q <= ctab_d;
            dtab_q <= dtab_d;
            prdata_q <= prdata_d;
        end
    end

    // ==========================================================
    // List sequencer
    always_comb begin
        state_d = state_q;
        idx_d = idx_q;
        dwell_left_d = dwell_left_q;
        rep_left_d = rep_left_q;
        step_d = 1'b0;
        ext_prev_d = ext_trig_in;
        tick_d = (state_q == ST_RUN && !tick_done) ? tick_q + 32'h1 : '0;
        unique case (state_q)
            ST_IDLE: begin
                if (arm_cmd && !oc_trip) begin
                    state_d = ST_ARMED;
                    idx_d = '0;
                end
            end
            ST_ARMED: begin
                if (abort_cmd) begin
                    state_d = ST_IDLE;
                end else if (fire) begin
                    state_d = ST_RUN;
                    idx_d = '0;
                    dwell_left_d = clamp_dwell(dtab_q[0]);
                    rep_left_d = (rep_count_q > 16'h0001) ?
                        rep_count_q - 16'h0001 : 16'h0000;
                    step_d = 1'b1;
                end
            end
            ST_RUN: begin
                if (abort_cmd) begin
                    state_d = ST_IDLE;
                end else if (tick_done) begin
                    if (dwell_left_q != 16'h0001) begin
                        dwell_left_d = dwell_left_q - 16'h0001;
                    end else if (idx_q != last_idx) begin
                        idx_d = idx_q + 5'h01;
                        dwell_left_d = clamp_dwell(dtab_q[idx_q + 5'h01]);
                        step_d = 1'b1;
                    end else if (endless_q || rep_left_q != 16'h0000) begin
                        // Wrap without a gap cycle
                        idx_d = '0;
                        dwell_left_d = clamp_dwell(dtab_q[0]);
                        if (!endless_q) begin
                            rep_left_d = rep_left_q - 16'h0001;
                        end
                        step_d = 1'b1;
                    end else begin
                        // Index stays on the last entry
                        state_d = ST_IDLE;
                    end
                end
            end
            // The spare state code falls back to idle
            default: state_d = ST_IDLE;
        endcase
        if (oc_trip) begin
            state_d = ST_IDLE;
        end
        step_d = step_d && ctrl_q[`CTRL_STEP_TRIG];
        volt_sp_d = ctrl_q[`CTRL_VOLT_LIST] ? vtab_q[idx_q]
            : volt_level_q;
        curr_sp_d = ctrl_q[`CTRL_CURR_LIST] ? ctab_q[idx_q]
            : curr_level_q;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
            idx_q <= '0;
            dwell_left_q <= 16'h0001;
            tick_q <= '0;
            rep_left_q <= 16'h0000;
            step_q <= 1'b0;
            ext_prev_q <= 1'b0;
            volt_sp_q <= `LEVEL_RST;
            curr_sp_q <= `LEVEL_RST;
        end else begin
            state_q <= state_d;
            idx_q <= idx_d;
            dwell_left_q <= dwell_left_d;
            tick_q <= tick_d;
            rep_left_q <= rep_left_d;
            step_q <= step_d;
            ext_prev_q <= ext_prev_d;
            volt_sp_q <= volt_sp_d;
            curr_sp_q <= curr_sp_d;
        end
    end

    // ==========================================================
    // Overcurrent protection delay and edge memory
    always_comb begin
        cc_prev_d = constant_current_regulation;
        if (ctrl_q[`CTRL_OCP_EN] && constant_current_regulation) begin
            // Saturate: a delay lowered mid-event must still trip
            oc_cnt_d = (oc_cnt_q >= prot_delay_q) ? oc_cnt_q
                : oc_cnt_q + 16'h0001;
        end else begin
            oc_cnt_d = 16'h0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            oc_cnt_q <= 16'h0000;
            cc_prev_q <= 1'b0;
        end else begin
            oc_cnt_q <= oc_cnt_d;
            cc_prev_q <= cc_prev_d;
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_armed_fire;
        state_q == ST_ARMED && fire && !abort_cmd && !oc_trip;
    endsequence

    sequence s_started;
        state_q == ST_RUN && idx_q == 5'h00;
    endsequence

    a_arm_waits_trigger: assert property (
        state_q == ST_ARMED && !fire |=> state_q != ST_RUN)
        else $error("List ran without a trigger");
    a_wait_bit_five: assert property (
        state_q == ST_IDLE && arm_cmd && !oc_trip
        |=> oper_cond[`OPER_WAIT])
        else $error("Waiting bit not set after arming");
    a_fire_always_taken: assert property (
        s_armed_fire |=> s_started)
        else $error("Trigger while armed did not start list");
    a_trigger_loads_level: assert property (
        s_armed_fire |=> volt_level_q == $past(post_trig_q))
        else $error("Post-trigger voltage not applied");
    a_dwell_advance: assert property (
        state_q == ST_RUN && tick_done && dwell_left_q == 16'h0001
        && idx_q != last_idx && !abort_cmd && !oc_trip
        |=> idx_q == $past(idx_q) + 5'h01)
        else $error("Entry did not advance after dwell");
    a_endless_wrap: assert property (
        state_q == ST_RUN && tick_done && dwell_left_q == 16'h0001
        && idx_q == last_idx && endless_q && !abort_cmd && !oc_trip
        |=> state_q == ST_RUN && idx_q == 5'h00)
        else $error("Endless list did not wrap");
    a_last_value_held: assert property (
        state_q == ST_RUN && tick_done && dwell_left_q == 16'h0001
        && idx_q == last_idx && !endless_q && rep_left_q == 16'h0000
        |=> state_q == ST_IDLE && idx_q == $past(idx_q))
        else $error("Last entry not kept after list end");
    a_volt_from_table: assert property (
        ctrl_q[`CTRL_VOLT_LIST] |=> volt_sp_q == $past(vtab_q[idx_q]))
        else $error("Voltage set point not from table");
    a_oc_rise_latch: assert property (
        ques_ptr_q[`QUES_OC] && !cc_prev_q && constant_current_regulation
        |=> ques_event_q[`QUES_OC])
        else $error("Overcurrent rise not latched");
    a_srq_raise: assert property (
        (ques_event_q[`QUES_OC] && ques_mask_q[`QUES_OC]
        && sre_q[`SRE_QUES]) |-> srq)
        else $error("Service request missing");
    a_trip_halts: assert property (
        oc_trip |=> !output_on && state_q == ST_IDLE)
        else $error("Protection did not halt output and list");
    a_zero_delay_trip: assert property (
        ctrl_q[`CTRL_OCP_EN] && prot_delay_q == 16'h0000
        && constant_current_regulation |-> oc_trip)
        else $error("Zero delay protection not immediate");
endmodule

// ==== bench/apb_host.sv ====
// Host model: APB master issuing register transfers
module apb_host (
    input wire logic pclk,
    output power_list_pkg::addr_t paddr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [31:0] pwdata,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr
);
    timeunit 1ns;
    timeprecision 1ns;
    import power_list_pkg::*;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
    end
    // ==========================================
    // Transfer
    // Request held until pready is seen high at an edge
    task automatic xfer(input logic w, input addr_t a,
        input logic [31:0] d, output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

// ==== bench/power_list_sequencer_test.sv ====
// Self-checking bench for the list sequencer
`include "power_list_map.svh"
module power_list_sequencer_test;
    timeunit 1ns;
    timeprecision 1ns;
    import power_list_pkg::*;
    // Short tick keeps dwell runs to a few cycles
    localparam int TK = 4;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic cc = 1'b0;
    logic ext = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, err;
    logic trig_out, output_on, srq;
    addr_t paddr;
    logic [31:0] pwdata, prdata, rdat;
    level_t volt_setpoint, curr_limit, hv;
    int num_errors = 0;
    int samples_checked = 0;
    int cyc = 0;
    int pulses = 0;
    always #10 pclk = ~pclk;
    apb_host apb_host_inst (.pclk(pclk), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr));
    power_list_sequencer #(.TICK_CYCLES(TK)) power_list_sequencer_inst (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .constant_current_regulation(cc), .ext_trig_in(ext),
        .trig_out(trig_out), .output_on(output_on),
        .volt_setpoint(volt_setpoint), .curr_limit(curr_limit), .srq(srq));
    always @(posedge pclk) begin
        cyc++;
        if (trig_out === 1'b1) pulses++;
        if (cyc == 5000) begin
            num_errors++;
            end_of_test();
        end
    end
    // ==========================================
    // Tasks
    task automatic tick();
        @(posedge pclk);
        #1;
    endtask
    task automatic chk(input string n, input logic [31:0] e, g);
        samples_checked++;
        if (g !== e) begin
            $display("BAD %s exp %h got %h", n, e, g);
            num_errors++;
        end
    endtask
    task automatic wr(input addr_t a, input logic [31:0] d);
        apb_host_inst.xfer(1'b1, a, d, rdat, err);
    endtask
    task automatic rd(input addr_t a, input logic [31:0] e);
        apb_host_inst.xfer(1'b0, a, 32'h0, rdat, err);
        chk($sformatf("reg %h", a), e, rdat);
    endtask
    function automatic level_t sel(input logic c);
        return c ? curr_limit : volt_setpoint;
    endfunction
    // Cycles an entry stays on the chosen set point
    task automatic dw(input logic c, input level_t v, input int n);
        int k;
        k = 0;
        while (sel(c) !== v) tick();
        while (sel(c) === v) begin
            tick();
            k++;
        end
        chk("dwell", 32'(n), 32'(k));
    endtask
    task automatic arm();
        wr(`OFS_CMD, 32'h1);
        rdat = 32'h0;
        while (rdat[`OPER_WAIT] !== 1'b1)
            apb_host_inst.xfer(1'b0, `OFS_OPER_COND, 32'h0, rdat, err);
        rd(`OFS_OPER_COND, 32'h20);
    endtask
    task automatic end_of_test();
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ==========================================
    // Sequence
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd(`OFS_CTRL, 32'h0);
        rd(`OFS_LIST_LEN, 32'h1);
        rd(`OFS_REPEAT, 32'h1);
        rd(12'h03c, 32'h0);
        chk("slverr", 32'h1, 32'(err));
        wr(`OFS_LIST_LEN, 32'h3);
        for (int i = 0; i < 3; i++) begin
            wr(`OFS_VOLT_TAB + addr_t'(4 * i), 32'(5 + 2 * i));
            wr(`OFS_CURR_TAB + addr_t'(4 * i), 32'(16 * i + 32));
            wr(`OFS_DWELL_TAB + addr_t'(4 * i), 32'(i + 1));
        end
        wr(`OFS_CTRL, 32'h21);
        arm();
        repeat (20) tick();
        rd(`OFS_OPER_COND, 32'h20);
        wr(`OFS_CMD, 32'h2);
        dw(1'b0, 16'h7, 2 * TK);
        repeat (40) tick();
        chk("hold", 32'h9, 32'(volt_setpoint));
        chk("pulses", 32'h3, 32'(pulses));
        wr(`OFS_CMD, 32'h4);
        wr(`OFS_REPEAT, 32'h10000);
        wr(`OFS_POST_TRIG, 32'hc);
        wr(`OFS_QUES_MASK, 32'h2);
        wr(`OFS_QUES_PTR, 32'h2);
        wr(`OFS_SRQ_MASK, 32'h8);
        wr(`OFS_PROT_DELAY, 32'h0);
        wr(`OFS_CTRL, 32'h1e);
        arm();
        @(posedge pclk);
        ext <= 1'b1;
        @(posedge pclk);
        ext <= 1'b0;
        dw(1'b1, 16'h30, 2 * TK);
        dw(1'b1, 16'h40, 3 * TK);
        dw(1'b1, 16'h20, TK);
        chk("volt", 32'hc, 32'(volt_setpoint));
        chk("on", 32'h1, 32'(output_on));
        @(posedge pclk);
        cc <= 1'b1;
        repeat (2) tick();
        chk("trip", 32'h0, 32'(output_on));
        chk("srq", 32'h1, 32'(srq));
        hv = curr_limit;
        repeat (30) tick();
        chk("halt", 32'(hv), 32'(curr_limit));
        rd(`OFS_QUES_EVENT, 32'h2);
        rd(`OFS_QUES_COND, 32'h2);
        rd(`OFS_STATUS_BYTE, 32'h48);
        rd(`OFS_OPER_COND, 32'h0);
        // Level still high: a cleared event must not come back
        wr(`OFS_QUES_EVENT, 32'h2);
        tick();
        chk("srq", 32'h0, 32'(srq));
        end_of_test();
    end
endmodule
